// ===== rtl/mdbs_decoder.sv
`timescale 1ns/10ps
module mdbs_decoder
  import mdbs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              battery_well_reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              swap_strap,
  input  wire logic [31:0]       memory_ceiling,
  input  wire logic              hub_valid,
  input  wire logic [31:0]       hub_addr,
  input  wire logic              hub_lock,
  output logic                   hub_done,
  output mdbs_pkg::mdbs_target_type hub_target,
  output logic [31:0]            hub_fwd_addr,
  input  wire logic              pci_unclaimed,
  output logic                   lpc_claim,
  input  wire logic              pci_valid,
  input  wire logic [31:0]       pci_addr,
  output logic                   pci_done,
  output mdbs_pkg::mdbs_route_type pci_route
);
  import mdbs_pkg::*;

  // ==========================================================
  // Configuration state
  logic [7:0]  flash_dec;
  logic [3:0]  flash_dec2;
  logic        sub_en;
  logic        lockdown;
  logic [31:0] lan_bar;
  logic [31:0] stor_bar;
  logic [31:0] usb_bar;
  logic [1:0]  tmr_sel;
  logic        tmr_en;
  logic [11:0] brg_base;
  logic [11:0] brg_limit;
  logic        lock_err;
  logic        strap_forced;
  logic        strap_taken;
  logic        swap_on;

  // ==========================================================
  // APB slave: one-cycle access phase
  logic        setup;
  logic        wr_fire;
  logic        mapped;
  logic [31:0] rd_word;

  assign setup   = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;

  always_comb begin
    mapped  = 1'b1;
    rd_word = REG_RST;
    case (paddr)
      OFS_FLASH_DEC:  rd_word[7:0] = flash_dec;
      OFS_FLASH_DEC2: rd_word[3:0] = flash_dec2;
      OFS_SWAP: begin
        rd_word[BIT_EN]     = swap_on;
        rd_word[BIT_FORCED] = strap_forced;
      end
      OFS_CTRL: begin
        rd_word[BIT_SUB_EN] = sub_en;
        rd_word[BIT_LOCKDN] = lockdown;
      end
      OFS_LAN_BAR:    rd_word = lan_bar;
      OFS_STOR_BAR:   rd_word = stor_bar;
      OFS_USB_BAR:    rd_word = usb_bar;
      OFS_TIMER: begin
        rd_word[1:0]        = tmr_sel;
        rd_word[BIT_TMR_EN] = tmr_en;
      end
      OFS_BRG_BASE:   rd_word[31:20] = brg_base;
      OFS_BRG_LIMIT:  rd_word[31:20] = brg_limit;
      OFS_STATUS: begin
        rd_word[BIT_LOCKERR] = lock_err;
        rd_word[6:4]         = hub_target;
      end
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= REG_RST;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_dec  <= FLASH_DEC_RST;
      flash_dec2 <= FLASH_DEC2_RST;
      sub_en     <= 1'b0;
      lockdown   <= 1'b0;
      lan_bar    <= REG_RST;
      stor_bar   <= REG_RST;
      usb_bar    <= REG_RST;
      tmr_sel    <= 2'h0;
      tmr_en     <= 1'b0;
      brg_base   <= 12'hFFF;
      brg_limit  <= 12'h000;
    end else if (wr_fire) begin
      case (paddr)
        OFS_FLASH_DEC:  flash_dec  <= pwdata[7:0];
        OFS_FLASH_DEC2: flash_dec2 <= pwdata[3:0];
        OFS_CTRL: begin
          sub_en   <= pwdata[BIT_SUB_EN];
          // Lock-down only releases with the platform reset
          lockdown <= lockdown | pwdata[BIT_LOCKDN];
        end
        OFS_LAN_BAR:    lan_bar  <= {pwdata[31:LAN_LOG2], LAN_LOG2'(0)} | 32'(pwdata[BIT_EN]);
        OFS_STOR_BAR:   stor_bar <= {pwdata[31:BLK_LOG2], BLK_LOG2'(0)} | 32'(pwdata[1:0]);
        OFS_USB_BAR:    usb_bar  <= {pwdata[31:BLK_LOG2], BLK_LOG2'(0)} | 32'(pwdata[BIT_EN]);
        OFS_TIMER: begin
          tmr_sel <= pwdata[1:0];
          tmr_en  <= pwdata[BIT_TMR_EN];
        end
        OFS_BRG_BASE:   brg_base  <= pwdata[31:20];
        OFS_BRG_LIMIT:  brg_limit <= pwdata[31:20];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Strap caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken  <= 1'b0;
      strap_forced <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      strap_forced <= swap_strap;
    end
  end

  mdbs_swap u_swap (
    .pclk                 (pclk),
    .battery_well_reset_n (battery_well_reset_n),
    .forced               (strap_forced),
    .wr_en                (wr_fire && paddr == OFS_SWAP && !lockdown),
    .wr_val               (pwdata[BIT_EN]),
    .swap                 (swap_on)
  );

  // ==========================================================
  // Hub-side decode
  logic hub_mem;
  logic hub_flash;
  logic hub_apic;
  logic hub_timer;
  logic hub_lan;
  logic hub_stor;
  logic hub_usb;
  logic hub_any;
  logic hub_swap;
  logic hub_mmio;

  assign hub_mem = (hub_addr <= LOW_MEM_HI) ||
                   (hub_addr >= HIGH_MEM_LO && hub_addr < memory_ceiling);
  assign hub_flash = flash_hit(hub_addr, flash_dec, flash_dec2);
  assign hub_apic  = apic_hit(hub_addr);
  assign hub_timer = tmr_en && hub_addr[31:14] == TIMER_TOP &&
                     hub_addr[13:12] == tmr_sel && hub_addr[11:10] == 2'h0;

  mdbs_window #(.SIZE_LOG2(LAN_LOG2)) u_lan (
    .addr   (hub_addr),
    .base   (lan_bar),
    .enable (lan_bar[BIT_EN]),
    .hit    (hub_lan)
  );

  mdbs_window #(.SIZE_LOG2(BLK_LOG2)) u_stor (
    .addr   (hub_addr),
    .base   (stor_bar),
    .enable (stor_bar[BIT_EN] && stor_bar[BIT_CFG]),
    .hit    (hub_stor)
  );

  mdbs_window #(.SIZE_LOG2(BLK_LOG2)) u_usb (
    .addr   (hub_addr),
    .base   (usb_bar),
    .enable (usb_bar[BIT_EN]),
    .hit    (hub_usb)
  );

  assign hub_any  = hub_mem || hub_flash || hub_apic || hub_timer ||
                    hub_lan || hub_stor || hub_usb;
  assign hub_mmio = hub_usb || hub_timer || hub_stor;
  // Feature space (bit 22 low in the top 16 MiB) never swaps
  assign hub_swap = swap_on && hub_flash && hub_addr >= SWAP_FLOOR &&
                    hub_addr[BIT_FEATURE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hub_done     <= 1'b0;
      hub_target   <= TGT_PCI;
      hub_fwd_addr <= REG_RST;
    end else begin
      hub_done <= hub_valid;
      if (hub_valid) begin
        hub_fwd_addr <= hub_addr ^ (32'(hub_swap) << BIT_SWAP);
        if (hub_mem) begin
          hub_target <= TGT_MEM;
        end else if (hub_flash) begin
          hub_target <= TGT_FLASH;
        end else if (hub_apic) begin
          hub_target <= TGT_APIC;
        end else if (hub_timer) begin
          hub_target <= TGT_TIMER;
        end else if (hub_usb) begin
          hub_target <= TGT_USB;
        end else if (hub_stor) begin
          hub_target <= TGT_STOR;
        end else if (hub_lan) begin
          hub_target <= TGT_LAN;
        end else begin
          hub_target <= TGT_PCI;
        end
      end
    end
  end

  // Lock is dropped on these windows; flag it, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_err <= 1'b0;
    end else if (hub_valid && hub_lock && hub_mmio) begin
      lock_err <= 1'b1;
    end else if (wr_fire && paddr == OFS_STATUS && pwdata[BIT_LOCKERR]) begin
      lock_err <= 1'b0;
    end
  end

  // ==========================================================
  // Subtractive forward to the low-pin-count bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpc_claim <= 1'b0;
    end else begin
      lpc_claim <= pci_unclaimed && sub_en;
    end
  end

  // ==========================================================
  // PCI master decode
  logic pci_bridge;
  logic pci_apic;
  logic pci_flash;

  assign pci_bridge = pci_addr[31:BRG_LOG2] >= brg_base &&
                      pci_addr[31:BRG_LOG2] <= brg_limit;
  assign pci_apic   = apic_hit(pci_addr);
  assign pci_flash  = flash_hit(pci_addr, flash_dec, flash_dec2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pci_done  <= 1'b0;
      pci_route <= RT_PEER;
    end else begin
      pci_done <= pci_valid;
      if (pci_valid) begin
        if (pci_bridge) begin
          pci_route <= RT_PEER;
        end else if (pci_apic) begin
          pci_route <= RT_APIC;
        end else if (pci_flash) begin
          pci_route <= RT_LPC;
        end else begin
          // Hub-only windows are not looked at here at all
          pci_route <= RT_UP;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hub_unclaimed;
    hub_valid && !hub_any;
  endsequence
  sequence s_swap_top;
    hub_valid && swap_on && hub_flash && hub_addr >= SWAP_FLOOR && hub_addr[BIT_FEATURE];
  endsequence
  sequence s_pci_plain;
    pci_valid && !pci_bridge && !pci_apic && !pci_flash;
  endsequence
  sequence s_legacy;
    hub_valid && hub_addr >= LEGACY_LO && hub_addr <= LEGACY_HI;
  endsequence
  sequence s_always_flash;
    hub_valid && !hub_mem && hub_addr[31:24] == FLASH_TOP && hub_addr[23] && hub_addr[21:19] == ALWAYS_IDX;
  endsequence

  AST_HUB_TO_PCI: assert property (s_hub_unclaimed |=> hub_done && hub_target == TGT_PCI)
    else $error("unclaimed hub cycle not sent to PCI");
  AST_SUBTRACTIVE: assert property (pci_unclaimed |=> lpc_claim == $past(sub_en))
    else $error("subtractive claim wrong");
  AST_PEER: assert property (pci_valid && pci_bridge |=> pci_done && pci_route == RT_PEER)
    else $error("bridge range cycle was claimed");
  AST_UPSTREAM: assert property (s_pci_plain |=> pci_route == RT_UP)
    else $error("master cycle not sent upstream");
  AST_NO_HUB_ONLY: assert property (pci_done |-> pci_route != RT_LPC || $past(pci_flash))
    else $error("master cycle claimed outside flash");
  AST_LOW_MEM: assert property (hub_valid && hub_addr <= LOW_MEM_HI |=> hub_target == TGT_MEM)
    else $error("low memory misrouted");
  AST_SWAP_A16: assert property (s_swap_top |=> hub_fwd_addr[BIT_SWAP] != $past(hub_addr[BIT_SWAP]))
    else $error("address bit 16 not inverted");
  AST_NO_SWAP_LOW: assert property (hub_valid && hub_addr < SWAP_FLOOR |=> hub_fwd_addr == $past(hub_addr))
    else $error("address below swap floor altered");
  // Software may clear the flag right after it is set
  AST_LOCK_FLAG: assert property (hub_valid && hub_lock && hub_mmio |=> lock_err ##1 (lock_err || $past(wr_fire)))
    else $error("ignored lock not flagged");
  AST_LEGACY: assert property (s_legacy |=> (hub_target == TGT_FLASH) == $past(flash_dec[BIT_LEG_EN]))
    else $error("legacy segment claim ignores its enable");
  AST_APIC_CLAIM: assert property (hub_valid && !hub_mem && hub_addr >= APIC_LO && hub_addr <= APIC_HI
    |=> hub_target == TGT_APIC)
    else $error("interrupt router window not claimed");
  AST_ALWAYS_FLASH: assert property (s_always_flash |=> hub_target == TGT_FLASH)
    else $error("fixed flash window not claimed");
  AST_TIMER_DIRECT: assert property (hub_valid && hub_timer && !hub_mem |=> hub_target == TGT_TIMER)
    else $error("timer window left to PCI");
  AST_SWAP_PASS: assert property (hub_valid && !swap_on |=> hub_fwd_addr == $past(hub_addr))
    else $error("address altered with swap off");
  AST_PCI_FLASH: assert property (pci_valid && !pci_bridge && pci_flash |=> pci_route == RT_LPC)
    else $error("master flash cycle sent upstream");
endmodule

// ===== rtl/mdbs_pkg.sv
// Summary of operation
// - Hub cycles hitting no internal target are passed to PCI.
// - With subtractive decode on, unclaimed PCI cycles go to the low-pin-count bus.
// - PCI master cycles in the bridge forwarding range are left for peers.
// - Other PCI master cycles outside interrupt-router and flash ranges go upstream.
// - Hub-only windows are never claimed for PCI masters.
// - Zero to 0xDFFFF and 1 MiB up to the memory ceiling are main memory.
// - Segment 0xE0000-0xFFFFF is flash only while decode-enable bit 7 is set.
// - Window 0xFEC00000-0xFEC00100 goes to the interrupt router.
// - Decode-enable bits 0-6 each open a pair of 512 KiB flash windows.
// - Top flash pair is always decoded; its top two 64 KiB blocks swap.
// - Decode-enable-2 bits 0-3 each open a pair of 1 MiB flash windows.
// - Network controller claims a 4 KiB window set by its enabled base.
// - Storage and USB host claim 1 KiB windows when enabled.
// - Event timers claim one of four 1 KiB windows at 0xFED0X000.
// - USB host and timer windows decode from the hub, never on PCI.
// - Locked accesses to USB, timer or storage windows are not honoured.
// - Swap bit set inverts address bit 16 for flash cycles at 0xFFFE0000 and above.
// - Swap bit lives in the battery well; of the resets, only its own clears it.
// - With swap, top 64 KiB block and the one below trade places.
// - A strap forcing swap stops software clearing the swap bit.
// - Inversion applies to flash memory space, never to feature space.
// - Swap never affects addresses below 0xFFFE0000.
package mdbs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_FLASH_DEC  = 8'h00;
  localparam logic [7:0] OFS_FLASH_DEC2 = 8'h04;
  localparam logic [7:0] OFS_SWAP       = 8'h08;
  localparam logic [7:0] OFS_CTRL       = 8'h0C;
  localparam logic [7:0] OFS_LAN_BAR    = 8'h10;
  localparam logic [7:0] OFS_STOR_BAR   = 8'h14;
  localparam logic [7:0] OFS_USB_BAR    = 8'h18;
  localparam logic [7:0] OFS_TIMER      = 8'h1C;
  localparam logic [7:0] OFS_BRG_BASE   = 8'h20;
  localparam logic [7:0] OFS_BRG_LIMIT  = 8'h24;
  localparam logic [7:0] OFS_STATUS     = 8'h28;
  // ==========================================================
  // Field positions and reset values
  localparam int BIT_EN      = 0;
  localparam int BIT_CFG     = 1;
  localparam int BIT_SUB_EN  = 0;
  localparam int BIT_LOCKDN  = 1;
  localparam int BIT_FORCED  = 1;
  localparam int BIT_TMR_EN  = 7;
  localparam int BIT_LOCKERR = 0;
  localparam int BIT_LEG_EN  = 7;
  localparam int BIT_FEATURE = 22;
  localparam int BIT_SWAP    = 16;
  localparam logic [7:0]  FLASH_DEC_RST  = 8'h00;
  localparam logic [3:0]  FLASH_DEC2_RST = 4'h0;
  localparam logic [31:0] REG_RST        = 32'h0000_0000;
  // ==========================================================
  // Memory map
  localparam logic [31:0] LOW_MEM_HI  = 32'h000D_FFFF;
  localparam logic [31:0] HIGH_MEM_LO = 32'h0010_0000;
  localparam logic [31:0] LEGACY_LO   = 32'h000E_0000;
  localparam logic [31:0] LEGACY_HI   = 32'h000F_FFFF;
  localparam logic [31:0] APIC_LO     = 32'hFEC0_0000;
  localparam logic [31:0] APIC_HI     = 32'hFEC0_0100;
  localparam logic [17:0] TIMER_TOP   = 18'h3FB40;
  localparam logic [7:0]  FLASH_TOP   = 8'hFF;
  localparam logic [2:0]  ALWAYS_IDX  = 3'h7;
  localparam logic [31:0] SWAP_FLOOR  = 32'hFFFE_0000;
  localparam int LAN_LOG2 = 12;
  localparam int BLK_LOG2 = 10;
  localparam int BRG_LOG2 = 20;
  // ==========================================================
  // Targets and routes
  typedef enum logic [2:0] {
    TGT_MEM   = 3'b000,
    TGT_FLASH = 3'b001,
    TGT_APIC  = 3'b010,
    TGT_LAN   = 3'b011,
    TGT_STOR  = 3'b100,
    TGT_USB   = 3'b101,
    TGT_TIMER = 3'b110,
    TGT_PCI   = 3'b111
  } mdbs_target_type;
  typedef enum logic [1:0] {
    RT_UP   = 2'b00,
    RT_APIC = 2'b01,
    RT_LPC  = 2'b10,
    RT_PEER = 2'b11
  } mdbs_route_type;
  // ==========================================================
  // Shared decode
  function automatic logic flash_hit(input logic [31:0] a, input logic [7:0] dec,
                                     input logic [3:0] dec2);
    logic hit;
    hit = 1'b0;
    if (a >= LEGACY_LO && a <= LEGACY_HI) begin
      hit = dec[BIT_LEG_EN];
    end else if (a[31:24] == FLASH_TOP) begin
      if (a[23]) begin
        hit = (a[21:19] == ALWAYS_IDX) || dec[a[21:19]];
      end else begin
        hit = dec2[a[21:20]];
      end
    end
    return hit;
  endfunction
  function automatic logic apic_hit(input logic [31:0] a);
    return (a >= APIC_LO) && (a <= APIC_HI);
  endfunction
endpackage

// ===== rtl/mdbs_window.sv
`timescale 1ns/10ps
module mdbs_window #(
  parameter int SIZE_LOG2 = 12
) (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base,
  input  wire logic        enable,
  output logic             hit
);
  if (SIZE_LOG2 < 1 || SIZE_LOG2 > 31) begin
    $error("window size out of range");
  end
  assign hit = enable && (addr[31:SIZE_LOG2] == base[31:SIZE_LOG2]);
endmodule

// ===== rtl/mdbs_swap.sv
`timescale 1ns/10ps
module mdbs_swap (
  input  wire logic pclk,
  input  wire logic battery_well_reset_n,
  input  wire logic forced,
  input  wire logic wr_en,
  input  wire logic wr_val,
  output logic      swap
);
  // Of the resets only the battery-well one clears it, so a crash mid-update boots the copy
  always_ff @(posedge pclk or negedge battery_well_reset_n) begin
    if (!battery_well_reset_n) begin
      swap <= 1'b0;
    end else if (forced) begin
      swap <= 1'b1;
    end else if (wr_en) begin
      swap <= wr_val;
    end
  end

  AST_FORCED_HOLDS: assert property (@(posedge pclk) disable iff (!battery_well_reset_n)
    forced |=> swap)
    else $error("forced swap bit was cleared");
endmodule

// ===== test/mdbs_host_model.sv
`timescale 1ns/10ps
module mdbs_host_model #(
  parameter logic [31:0] CEILING = 32'h4000_0000
) (
  input  wire logic        pclk,
  output logic             hub_valid,
  output logic [31:0]      hub_addr,
  output logic             hub_lock,
  output logic [31:0]      memory_ceiling
);
  // ==========================================================
  // Host-side state
  // Ceiling is a host setting, fixed for the whole run
  assign memory_ceiling = CEILING;
  initial begin
    hub_valid = 1'b0;
    hub_addr  = 32'h0000_0000;
    hub_lock  = 1'b0;
  end
  // ==========================================================
  // One memory cycle per call; locked only when the caller asks
  task automatic cycle(input logic [31:0] a, input logic lk);
    @(posedge pclk);
    hub_valid <= 1'b1;
    hub_addr  <= a;
    hub_lock  <= lk;
    @(posedge pclk);
    hub_valid <= 1'b0;
    hub_lock  <= 1'b0;
    // Scrambled idle address so nothing leans on a stale value
    hub_addr  <= ~a;
  endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
  import mdbs_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        battery_well_reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        swap_strap;
  logic [31:0] memory_ceiling;
  logic        hub_valid;
  logic [31:0] hub_addr;
  logic        hub_lock;
  logic        hub_done;
  mdbs_target_type hub_target;
  logic [31:0] hub_fwd_addr;
  logic        pci_unclaimed;
  logic        lpc_claim;
  logic        pci_valid;
  logic [31:0] pci_addr;
  logic        pci_done;
  mdbs_route_type pci_route;
  int          bad_count;
  int          compares;

  mdbs_decoder i_dut (.pclk(pclk), .presetn(presetn), .battery_well_reset_n(battery_well_reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .swap_strap(swap_strap), .memory_ceiling(memory_ceiling),
    .hub_valid(hub_valid), .hub_addr(hub_addr), .hub_lock(hub_lock), .hub_done(hub_done),
    .hub_target(hub_target), .hub_fwd_addr(hub_fwd_addr), .pci_unclaimed(pci_unclaimed),
    .lpc_claim(lpc_claim), .pci_valid(pci_valid), .pci_addr(pci_addr), .pci_done(pci_done),
    .pci_route(pci_route));
  mdbs_host_model i_host (.pclk(pclk), .hub_valid(hub_valid), .hub_addr(hub_addr),
    .hub_lock(hub_lock), .memory_ceiling(memory_ceiling));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
    check({31'h0, er}, {31'h0, experr});
  endtask
  task automatic hub_chk(input logic [31:0] a, input logic lk, input logic [2:0] t, input logic [31:0] f);
    i_host.cycle(a, lk);
    #1;
    check({31'h0, hub_done}, 32'h1);
    check({29'h0, hub_target}, {29'h0, t});
    check(hub_fwd_addr, f);
  endtask
  task automatic hc(input logic [31:0] a, input logic [2:0] t);
    hub_chk(a, 1'b0, t, a);
  endtask
  task automatic pci_chk(input logic [31:0] a, input logic [1:0] rt);
    @(posedge pclk);
    pci_valid <= 1'b1;
    pci_addr  <= a;
    @(posedge pclk);
    pci_valid <= 1'b0;
    pci_addr  <= ~a;
    #1;
    check({31'h0, pci_done}, 32'h1);
    check({30'h0, pci_route}, {30'h0, rt});
  endtask
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_map;
    rdchk(OFS_FLASH_DEC, 32'h0, 1'b0);
    rdchk(8'h2C, 32'h0, 1'b1);
    hc(32'h0000_0000, TGT_MEM);
    hc(32'h000D_FFFF, TGT_MEM);
    hc(32'h0010_0000, TGT_MEM);
    hc(32'h3FFF_FFFC, TGT_MEM);
    hc(32'h4000_0000, TGT_PCI);
    hc(32'h000E_0000, TGT_PCI);
    wr(OFS_FLASH_DEC, 32'h80);
    hc(32'h000E_0000, TGT_FLASH);
    hc(32'h000F_FFFF, TGT_FLASH);
    hc(32'hFEC0_0000, TGT_APIC);
    hc(32'hFEC0_0100, TGT_APIC);
    hc(32'hFEC0_0104, TGT_PCI);
    hc(32'hFFF8_0000, TGT_FLASH);
    hc(32'hFFB8_0000, TGT_FLASH);
  endtask
  task automatic t_flash;
    for (int i = 0; i < 7; i++) begin
      wr(OFS_FLASH_DEC, 32'h1 << i);
      hc(32'hFFC0_0000 + i * 32'h8_0000, TGT_FLASH);
      hc(32'hFF80_0000 + i * 32'h8_0000, TGT_FLASH);
      hc(32'hFFC0_0000 + ((i + 1) % 7) * 32'h8_0000, TGT_PCI);
    end
    for (int j = 0; j < 4; j++) begin
      wr(OFS_FLASH_DEC2, 32'h1 << j);
      hc(32'hFF40_0000 + j * 32'h10_0000, TGT_FLASH);
      hc(32'hFF00_0000 + j * 32'h10_0000, TGT_FLASH);
      hc(32'hFF40_0000 + ((j + 1) % 4) * 32'h10_0000, TGT_PCI);
    end
  endtask
  task automatic t_windows;
    hc(32'h8000_1000, TGT_PCI);
    wr(OFS_LAN_BAR, 32'h8000_1001);
    hc(32'h8000_1FFC, TGT_LAN);
    hc(32'h8000_2000, TGT_PCI);
    wr(OFS_STOR_BAR, 32'h9000_0401);
    hc(32'h9000_0400, TGT_PCI);
    wr(OFS_STOR_BAR, 32'h9000_0403);
    hc(32'h9000_07FC, TGT_STOR);
    wr(OFS_USB_BAR, 32'hA000_0001);
    hc(32'hA000_03FC, TGT_USB);
    hc(32'hA000_0400, TGT_PCI);
    hc(32'hFED0_0000, TGT_PCI);
    for (int x = 0; x < 4; x++) begin
      wr(OFS_TIMER, 32'h80 | x);
      hc(32'hFED0_0000 | (x << 12), TGT_TIMER);
      hc(32'hFED0_03FF | (x << 12), TGT_TIMER);
      hc(32'hFED0_0400 | (x << 12), TGT_PCI);
    end
    // A locked cycle to the host window is flagged, not honoured
    hub_chk(32'hA000_0000, 1'b1, TGT_USB, 32'hA000_0000);
    rdchk(OFS_STATUS, 32'h51, 1'b0);
    wr(OFS_STATUS, 32'h1);
    rdchk(OFS_STATUS, 32'h50, 1'b0);
  endtask
  task automatic t_pci;
    pci_chk(32'h0000_1000, RT_UP);
    pci_chk(32'hFEC0_0010, RT_APIC);
    pci_chk(32'hFFF8_0000, RT_LPC);
    pci_chk(32'hFFC0_0000, RT_UP);
    pci_chk(32'hA000_0000, RT_UP);
    pci_chk(32'hFED0_3000, RT_UP);
    wr(OFS_BRG_BASE, 32'h5000_0000);
    wr(OFS_BRG_LIMIT, 32'h5000_0000);
    pci_chk(32'h500F_FFFC, RT_PEER);
    pci_chk(32'h5010_0000, RT_UP);
  endtask
  task automatic t_subtr;
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CTRL, s);
      @(posedge pclk);
      pci_unclaimed <= 1'b1;
      @(posedge pclk);
      pci_unclaimed <= 1'b0;
      #1;
      check({31'h0, lpc_claim}, s);
    end
  endtask
  task automatic t_swap;
    hub_chk(32'hFFFF_1234, 1'b0, TGT_FLASH, 32'hFFFF_1234);
    // Update order: top block copied below before the swap bit goes up
    wr(OFS_SWAP, 32'h1);
    hub_chk(32'hFFFF_1234, 1'b0, TGT_FLASH, 32'hFFFE_1234);
    hub_chk(32'hFFFE_0010, 1'b0, TGT_FLASH, 32'hFFFF_0010);
    hub_chk(32'hFFBF_0000, 1'b0, TGT_FLASH, 32'hFFBF_0000);
    hub_chk(32'hFFFD_0000, 1'b0, TGT_FLASH, 32'hFFFD_0000);
    do_reset();
    rdchk(OFS_SWAP, 32'h1, 1'b0);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_SWAP, 32'h0);
    rdchk(OFS_SWAP, 32'h1, 1'b0);
    do_reset();
    @(posedge pclk);
    battery_well_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    battery_well_reset_n <= 1'b1;
    rdchk(OFS_SWAP, 32'h0, 1'b0);
    swap_strap <= 1'b1;
    do_reset();
    rdchk(OFS_SWAP, 32'h3, 1'b0);
    wr(OFS_SWAP, 32'h0);
    rdchk(OFS_SWAP, 32'h3, 1'b0);
    swap_strap <= 1'b0;
    do_reset();
    wr(OFS_SWAP, 32'h0);
    rdchk(OFS_SWAP, 32'h0, 1'b0);
  endtask
  // ==========================================================
  // Run control
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    bad_count = 0;
    compares = 0;
    presetn = 1'b0;
    battery_well_reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    swap_strap = 1'b0;
    pci_unclaimed = 1'b0;
    pci_valid = 1'b0;
    pci_addr = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    battery_well_reset_n <= 1'b1;
    t_map();
    t_flash();
    t_windows();
    t_pci();
    t_subtr();
    t_swap();
    wrap_up();
  end
endmodule
